// *** logic/motor_modulator.sv ***
// PDM or PWM modulator driving the motor from an 8-bit level
`timescale 1ns/1ps
module motor_modulator
    import motor_servo_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic [7:0] level,
    input  wire logic       pwm_sel,
    input  wire logic       enable,
    output logic            motor_out
);
    typedef struct packed {
        logic [7:0] ramp;
        logic [8:0] accum;
        logic       out;
    } mod_state_type;

    mod_state_type state;
    mod_state_type next_state;

    // first-order sigma-delta for PDM, sawtooth compare for PWM
    always_comb begin
        next_state      = state;
        next_state.ramp = state.ramp + 8'h01;
        next_state.accum = {1'b0, state.accum[7:0]} + {1'b0, level};
        if (!enable) begin
            next_state.out = 1'b0;
        end else if (pwm_sel) begin
            next_state.out = (state.ramp < level);
        end else begin
            next_state.out = next_state.accum[8];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign motor_out = state.out;

endmodule : motor_modulator

// *** logic/motor_servo_pkg.sv ***
// package with register map, field layout and types of the motor speed servo
package motor_servo_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] freq_setpoint_off  = 8'h00;
    localparam logic [7:0] fill_setpoint_off  = 8'h04;
    localparam logic [7:0] loop_gain_a_off    = 8'h08;
    localparam logic [7:0] loop_gain_b_off    = 8'h0C;
    localparam logic [7:0] integrator_mult_off = 8'h10;
    localparam logic [7:0] motor_mode_off     = 8'h14;
    localparam logic [7:0] integrator_low_off = 8'h18;
    localparam logic [7:0] integrator_high_off = 8'h1C;
    localparam logic [7:0] irq_status_b_off   = 8'h20;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int gain_a_kf_pos      = 0;   // frequency integrator gain [7:0]
    localparam int gain_a_ki_pos      = 8;   // position integrator gain [15:8]
    localparam int gain_b_g_pos       = 0;   // overall gain [7:0]
    localparam int gain_b_src_pos     = 8;   // freq_source_select
    localparam int mult_kf_pos        = 0;   // log2 divider of kf [2:0]
    localparam int mult_ki_pos        = 4;   // log2 divider of ki [6:4]
    localparam int mode_sel_pos       = 0;   // mode [1:0]
    localparam int mode_pwm_pos       = 2;   // 1 = PWM, 0 = PDM
    localparam int mode_freq_sw_pos   = 3;   // freq_loop_switch closed
    localparam int mode_pos_sw_pos    = 4;   // position_loop_switch closed
    localparam int mode_ovf_pos       = 5;   // overflow_opens_switches
    localparam int status_ovf_pos     = 0;   // motor_overflow_flag

    // ************************************************************
    // reset values and timing
    // ************************************************************
    localparam logic [7:0]  freq_setpoint_rst = 8'h00;
    localparam logic [7:0]  fill_setpoint_rst = 8'h7B;
    localparam logic [15:0] gain_a_rst        = 16'h0000;
    localparam logic [8:0]  gain_b_rst        = 9'h000;
    localparam logic [6:0]  mult_rst          = 7'h00;
    localparam logic [5:0]  mode_rst          = 6'h03;   // shut down, switches open
    localparam logic [15:0] integ_rst         = 16'h0000;
    localparam int          sample_period     = 24;      // clocks per input sample
    localparam logic [7:0]  open_loop_start   = 8'hE0;   // fixed drive in start
    localparam logic [7:0]  open_loop_stop    = 8'h20;   // fixed drive in stop
    localparam logic [7:0]  neutral_level     = 8'h80;

    typedef enum logic [1:0] {
        mode_start,
        mode_stop,
        mode_closed,
        mode_shutdown
    } motor_mode_type;

    // software-visible control
    typedef struct packed {
        logic [7:0]  freq_setpoint;
        logic [7:0]  fill_setpoint;
        logic [15:0] gain_a;
        logic [8:0]  gain_b;
        logic [6:0]  mult;
        logic [5:0]  mode;
    } ctrl_type;

    // wishbone answer group
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_answer_type;

endpackage : motor_servo_pkg

// *** logic/motor_speed_servo.sv ***
// motor speed servo: PI filter, register slave and mode control
`timescale 1ns/1ps
module motor_speed_servo
    import motor_servo_pkg::*;
#(
    parameter int data_width = 8
)
(
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    // classic wishbone slave
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [7:0]            adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [31:0]           dat_i,
    output logic [31:0]                dat_o,
    output logic                       ack_o,
    // measurements from the same clock domain
    input  wire logic [data_width-1:0] pll_freq,
    input  wire logic [data_width-1:0] buffer_fill_level,
    // motor drive
    output logic                       motor_out,
    output logic                       motor_enable
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        ctrl_type      ctrl;
        logic signed [15:0] integ;
        logic [4:0]    sample_cnt;
        logic [6:0]    kf_sub;
        logic [6:0]    ki_sub;
        logic [7:0]    drive;
        logic          overflow;
        logic          drive_en;
        wb_answer_type bus;
    } servo_state_type;

    servo_state_type state;
    servo_state_type next_state;
    logic            mod_out;

    // saturating add into the integrator, reporting overflow
    function automatic logic [16:0] sat_add(input logic signed [15:0] a,
                                            input logic signed [17:0] b);
        logic signed [18:0] sum;
        sum = 19'(a) + 19'(b);
        if (sum > 19'sd32767) begin
            sat_add = {1'b1, 16'h7FFF};
        end else if (sum < -19'sd32768) begin
            sat_add = {1'b1, 16'h8000};
        end else begin
            sat_add = {1'b0, sum[15:0]};
        end
    endfunction : sat_add

    // sub-sample mask: divider 2**n passes one sample in 2**n
    function automatic logic sub_pass(input logic [6:0] cnt, input logic [2:0] n);
        logic [6:0] mask;
        mask = 7'((8'h01 << n) - 8'h01);
        sub_pass = ((cnt & mask) == 7'h00);
    endfunction : sub_pass

    motor_mode_type     mode;
    logic               freq_sw;
    logic               pos_sw;
    logic               sample_tick;
    logic signed [8:0]  freq_err;
    logic signed [8:0]  pos_err;
    logic signed [17:0] freq_step;
    logic signed [17:0] pos_step;
    logic signed [17:0] prop;
    logic signed [26:0] gained;
    logic [16:0]        sum_a;
    logic [16:0]        sum_b;
    logic               gain_ovf;
    logic               wr;
    logic [31:0]        rd_data;
    logic [31:0]        wmask;

    // decoded controls
    always_comb begin
        mode    = motor_mode_type'(state.ctrl.mode[mode_sel_pos +: 2]);
        // overflow lets go of both switches when enabled
        freq_sw = state.ctrl.mode[mode_freq_sw_pos]
                  && !(state.overflow && state.ctrl.mode[mode_ovf_pos]);
        pos_sw  = state.ctrl.mode[mode_pos_sw_pos]
                  && !(state.overflow && state.ctrl.mode[mode_ovf_pos]);
        sample_tick = (state.sample_cnt == 5'(sample_period - 1));
    end

    // error terms against the set points
    always_comb begin
        if (state.ctrl.gain_b[gain_b_src_pos]) begin
            freq_err = 9'sd0 - $signed({1'b0, state.ctrl.freq_setpoint});
        end else begin
            freq_err = $signed({1'b0, pll_freq[7:0]})
                       - $signed({1'b0, state.ctrl.freq_setpoint});
        end
        // a full buffer means the motor runs fast
        pos_err   = $signed({1'b0, buffer_fill_level[7:0]})
                    - $signed({1'b0, state.ctrl.fill_setpoint});
        freq_step = 18'(freq_err * $signed({1'b0, state.ctrl.gain_a[gain_a_kf_pos +: 8]}));
        pos_step  = 18'(pos_err * $signed({1'b0, state.ctrl.gain_a[gain_a_ki_pos +: 8]}));
        prop      = 18'(freq_sw ? 18'(freq_err) : 18'sd0)
                    + 18'(pos_sw ? 18'(pos_err) : 18'sd0);
    end

    // frequency then position integration, each gated by its sub-sampler
    always_comb begin
        sum_a = sat_add(state.integ, freq_step);
        sum_b = sat_add(freq_sw && sub_pass(state.kf_sub, state.ctrl.mult[mult_kf_pos +: 3])
                        ? sum_a[15:0] : state.integ, pos_step);
    end

    // overall gain on integrator plus proportional part, scaled to 8 bits
    always_comb begin
        gained = 27'($signed({1'b0, state.ctrl.gain_b[gain_b_g_pos +: 8]})
                     * ($signed(18'(state.integ >>> 4)) + prop));
        gain_ovf = (gained >>> 8) > 27'sd127 || (gained >>> 8) < -27'sd128;
    end

    // register bus decode
    always_comb begin
        wr    = cyc_i && stb_i && we_i && !state.bus.ack;
        wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
        unique case (adr_i)
            freq_setpoint_off:   rd_data = {24'h0, state.ctrl.freq_setpoint};
            fill_setpoint_off:   rd_data = {24'h0, state.ctrl.fill_setpoint};
            loop_gain_a_off:     rd_data = {16'h0, state.ctrl.gain_a};
            loop_gain_b_off:     rd_data = {23'h0, state.ctrl.gain_b};
            integrator_mult_off: rd_data = {25'h0, state.ctrl.mult};
            motor_mode_off:      rd_data = {26'h0, state.ctrl.mode};
            integrator_low_off:  rd_data = {24'h0, state.integ[7:0]};
            integrator_high_off: rd_data = {24'h0, state.integ[15:8]};
            irq_status_b_off:    rd_data = {31'h0, state.overflow};
            default:             rd_data = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_state            = state;
        next_state.bus.ack    = cyc_i && stb_i && !state.bus.ack;
        next_state.bus.dat    = rd_data;
        next_state.sample_cnt = sample_tick ? 5'h00 : state.sample_cnt + 5'h01;

        // integrator updates only in closed loop at the sample rate
        if (mode == mode_closed && sample_tick) begin
            next_state.kf_sub = state.kf_sub + 7'h01;
            next_state.ki_sub = state.ki_sub + 7'h01;
            if (pos_sw && sub_pass(state.ki_sub, state.ctrl.mult[mult_ki_pos +: 3])) begin
                next_state.integ = $signed(sum_b[15:0]);
            end else if (freq_sw && sub_pass(state.kf_sub, state.ctrl.mult[mult_kf_pos +: 3]))
            begin
                next_state.integ = $signed(sum_a[15:0]);
            end
        end

        // level flag follows the overflow condition itself
        next_state.overflow = (mode == mode_closed) && (gain_ovf || sum_b[16]);

        // drive level by mode
        unique case (mode)
            mode_start:    next_state.drive = open_loop_start;
            mode_stop:     next_state.drive = open_loop_stop;
            mode_shutdown: next_state.drive = neutral_level;
            mode_closed: begin
                if (!freq_sw && !pos_sw) begin
                    next_state.drive = state.integ[15:8] ^ 8'h80;
                end else if (gain_ovf) begin
                    next_state.drive = gained[26] ? 8'h00 : 8'hFF;
                end else begin
                    next_state.drive = 8'(gained[15:8]) ^ 8'h80;
                end
            end
        endcase
        next_state.drive_en = (mode != mode_shutdown);

        // register writes, byte lanes honoured
        if (wr) begin
            unique case (adr_i)
                freq_setpoint_off: next_state.ctrl.freq_setpoint =
                    8'((dat_i & wmask) | ({24'h0, state.ctrl.freq_setpoint} & ~wmask));
                fill_setpoint_off: next_state.ctrl.fill_setpoint =
                    8'((dat_i & wmask) | ({24'h0, state.ctrl.fill_setpoint} & ~wmask));
                loop_gain_a_off: next_state.ctrl.gain_a =
                    16'((dat_i & wmask) | ({16'h0, state.ctrl.gain_a} & ~wmask));
                loop_gain_b_off: next_state.ctrl.gain_b =
                    9'((dat_i & wmask) | ({23'h0, state.ctrl.gain_b} & ~wmask));
                integrator_mult_off: next_state.ctrl.mult =
                    7'((dat_i & wmask) | ({25'h0, state.ctrl.mult} & ~wmask));
                motor_mode_off: next_state.ctrl.mode =
                    6'((dat_i & wmask) | ({26'h0, state.ctrl.mode} & ~wmask));
                integrator_low_off: begin
                    if (sel_i[0]) begin
                        next_state.integ[7:0] = dat_i[7:0];
                    end
                end
                integrator_high_off: begin
                    if (sel_i[0]) begin
                        next_state.integ[15:8] = dat_i[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state                    <= '0;
            state.ctrl.freq_setpoint <= freq_setpoint_rst;
            state.ctrl.fill_setpoint <= fill_setpoint_rst;
            state.ctrl.gain_a        <= gain_a_rst;
            state.ctrl.gain_b        <= gain_b_rst;
            state.ctrl.mult          <= mult_rst;
            state.ctrl.mode          <= mode_rst;
            state.integ              <= integ_rst;
            state.drive              <= neutral_level;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // modulator and outputs
    // ************************************************************
    motor_modulator u_mod (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .level     (state.drive),
        .pwm_sel   (state.ctrl.mode[mode_pwm_pos]),
        .enable    (state.drive_en),
        .motor_out (mod_out)
    );

    assign motor_out    = mod_out;
    assign motor_enable = state.drive_en;
    assign ack_o        = state.bus.ack;
    assign dat_o        = state.bus.dat;

endmodule : motor_speed_servo

// *** verification/motor_driver_model.sv ***
// motor driver stage model: averages the drive bitstream over 256 clocks
`timescale 1ns/1ps
module motor_driver_model
(
    input wire logic        ref_clk,
    input wire logic        motor_out,
    input wire logic        motor_enable,
    output logic     [8:0]  duty
);
    logic [255:0] hist = '0;

    // a disabled driver stage passes no power, so it counts as zero
    always_ff @(posedge ref_clk) begin
        hist <= {hist[254:0], motor_out & motor_enable};
    end
    assign duty = 9'($countones(hist));
endmodule : motor_driver_model

// *** verification/motor_servo_chk.sv ***
// concurrent checks on the motor speed servo ports
`timescale 1ns/1ps
module motor_servo_chk
    import motor_servo_pkg::*;
#(
    parameter int data_width = 8
)
(
    input wire logic                  ref_clk,
    input wire logic                  srst,
    input wire logic                  cyc_i,
    input wire logic                  stb_i,
    input wire logic                  we_i,
    input wire logic [7:0]            adr_i,
    input wire logic [3:0]            sel_i,
    input wire logic [31:0]           dat_i,
    input wire logic [31:0]           dat_o,
    input wire logic                  ack_o,
    input wire logic [data_width-1:0] pll_freq,
    input wire logic [data_width-1:0] buffer_fill_level,
    input wire logic                  motor_out,
    input wire logic                  motor_enable
);
    logic req;
    logic mode_wr;
    logic mode_wr_d;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    // a request that the slave has not yet answered
    assign req = cyc_i & stb_i & ~ack_o;

    // remember mode writes, motor_enable may follow one or two cycles late
    always_ff @(posedge ref_clk) begin
        mode_wr   <= ack_o & we_i & (adr_i == motor_mode_off);
        mode_wr_d <= mode_wr;
    end

    a_ack_follows: assert property (req |=> ack_o)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i) && $past(stb_i))
        else $error("ack without request");
    a_unmapped_zero: assert property (ack_o && !we_i && adr_i > irq_status_b_off |-> dat_o == '0)
        else $error("unmapped read not zero");
    a_run_enables: assert property (req && we_i && adr_i == motor_mode_off
        && dat_i[1:0] != 2'h3 |-> ##[1:3] motor_enable)
        else $error("drive not enabled after run mode write");
    a_stop_disables: assert property (req && we_i && adr_i == motor_mode_off
        && dat_i[1:0] == 2'h3 |-> ##[1:3] !motor_enable)
        else $error("drive still enabled after shut down write");
    a_enable_cause: assert property ($changed(motor_enable) |-> mode_wr || mode_wr_d || ack_o)
        else $error("drive enable moved without mode write");
    a_idle_out_low: assert property (!motor_enable [*3] |-> !motor_out)
        else $error("motor output active in shut down");
    a_reset_quiet: assert property (disable iff (1'b0)
        srst |=> !ack_o && !motor_enable && !motor_out && dat_o == '0)
        else $error("outputs not quiet after reset");

    c_mode_write: cover property (req && we_i && adr_i == motor_mode_off);
    c_drive_on: cover property (motor_enable && motor_out);
    c_integ_read: cover property (ack_o && !we_i && adr_i == integrator_high_off);
    c_ovf_read: cover property (ack_o && !we_i && adr_i == irq_status_b_off && dat_o[0]);
endmodule : motor_servo_chk

bind motor_speed_servo motor_servo_chk #(.data_width(data_width)) u_chk (
    .ref_clk(ref_clk), .srst(srst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pll_freq(pll_freq), .buffer_fill_level(buffer_fill_level),
    .motor_out(motor_out), .motor_enable(motor_enable));

// *** verification/motor_speed_servo_tb.sv ***
// self-checking bench for the motor speed servo
`timescale 1ns/1ps
module motor_speed_servo_tb
    import motor_servo_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [7:0]  pll_freq = 8'h00;
    logic [7:0]  buffer_fill_level = 8'h7B;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        motor_out;
    logic        motor_enable;
    logic [8:0]  duty;
    logic [16:0] seed = 17'h144D7;
    logic [31:0] rd;
    logic [31:0] hi;
    logic [31:0] v;
    int          errors = 0;
    int          checks_done = 0;
    logic [7:0]  offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [31:0] rstv [9] = '{32'h0, 32'h7B, 32'h0, 32'h0, 32'h0, 32'h3, 32'h0, 32'h0, 32'h0};
    logic [31:0] mask [5] = '{32'hFF, 32'hFF, 32'hFFFF, 32'h1FF, 32'h7F};

    motor_speed_servo uut (.ref_clk(ref_clk), .srst(srst), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .pll_freq(pll_freq), .buffer_fill_level(buffer_fill_level), .motor_out(motor_out),
        .motor_enable(motor_enable));
    motor_driver_model drv (.ref_clk(ref_clk), .motor_out(motor_out),
        .motor_enable(motor_enable), .duty(duty));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [16:0] lfsr_next(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr_next

    // CLV frequency set point for overspeed n on the 40 MHz system clock
    function automatic logic [7:0] clv_setpoint(input int n);
        return 8'($rtoi(256.0 * (1.0 - n * 4.3218e6 / (2.667 * 40.0e6))));
    endfunction : clv_setpoint

    task automatic rnd(output logic [31:0] r);
        seed = lfsr_next(seed);
        r[15:0] = seed[15:0];
        seed = lfsr_next(seed);
        r[31:16] = seed[15:0];
    endtask : rnd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // modulator averages may sit a few counts off the ideal level
    task automatic chk_near(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if ($isunknown(got) || (got - exp + 9'h004) > 9'h008) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_near

    // one classic cycle; the slave answer time is not assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50) errors++;
    endtask : wb

    task automatic end_sim;
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // ************************************************************
    // clock, watchdog and scenarios
    // ************************************************************
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // whole run needs about 3800 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        chk({30'h0, motor_enable, motor_out}, 32'h0);
        for (int i = 0; i < 9; i++) begin
            wb(1'b0, offs[i], 32'h0, rd);
            chk(rd, rstv[i]);
        end
        // random programming of set points, gains and multipliers
        for (int i = 0; i < 10; i++) begin
            rnd(v);
            pll_freq <= v[23:16];
            buffer_fill_level <= v[31:24];
            wb(1'b1, offs[i % 5], v, rd);
            wb(1'b0, offs[i % 5], 32'h0, rd);
            chk(rd, v & mask[i % 5]);
        end
        wb(1'b1, 8'h24, v, rd);
        wb(1'b0, 8'h24, 32'h0, rd);
        chk(rd, 32'h0);
        wb(1'b1, integrator_low_off, {24'h0, v[7:0]}, rd);
        wb(1'b1, integrator_high_off, {24'h0, v[15:8]}, rd);
        wb(1'b0, integrator_low_off, 32'h0, rd);
        wb(1'b0, integrator_high_off, 32'h0, hi);
        chk(rd, {24'h0, v[7:0]});
        chk(hi, {24'h0, v[15:8]});
        // open loop start and stop, PDM then PWM
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, motor_mode_off, {29'h0, m[1], 1'b0, m[0]}, rd);
            repeat (600) @(posedge ref_clk);
            chk({31'h0, motor_enable}, 32'h1);
            chk_near(duty, {1'b0, m[0] ? open_loop_stop : open_loop_start});
            wb(1'b0, integrator_high_off, 32'h0, rd);
            chk(rd, {24'h0, v[15:8]});
        end
        // both switches open: plain DAC of the integrator
        wb(1'b1, motor_mode_off, 32'h02, rd);
        wb(1'b1, integrator_low_off, 32'h00, rd);
        wb(1'b1, integrator_high_off, 32'hC0, rd);
        repeat (600) @(posedge ref_clk);
        // integrator is two's complement, drive is offset binary: -64 gives 0x40
        chk_near(duty, 9'h040);
        wb(1'b0, integrator_high_off, 32'h0, rd);
        chk(rd, 32'hC0);
        // zero errors hold the integrator; software keeps fill set point in 118..128
        buffer_fill_level <= 8'h7B;
        wb(1'b1, loop_gain_b_off, 32'h110, rd);
        wb(1'b1, freq_setpoint_off, 32'h00, rd);
        wb(1'b1, fill_setpoint_off, 32'h7B, rd);
        wb(1'b1, loop_gain_a_off, 32'h1010, rd);
        wb(1'b1, integrator_mult_off, 32'h00, rd);
        wb(1'b1, integrator_high_off, 32'h80, rd);
        wb(1'b1, motor_mode_off, 32'h1A, rd);
        repeat (240) @(posedge ref_clk);
        wb(1'b0, integrator_high_off, 32'h0, rd);
        chk(rd, 32'h80);
        // integrator sits at its floor, so only a fuller buffer can move it
        buffer_fill_level <= 8'h90;
        repeat (120) @(posedge ref_clk);
        wb(1'b0, integrator_high_off, 32'h0, rd);
        chk({31'h0, rd !== 32'h80}, 32'h1);
        // PLL source, frequency switch only
        buffer_fill_level <= 8'h7B;
        // PLL below the CLV set point pulls a centred integrator down
        pll_freq <= {1'b0, v[6:0]};
        wb(1'b1, motor_mode_off, 32'h02, rd);
        wb(1'b1, integrator_high_off, 32'h00, rd);
        wb(1'b1, loop_gain_b_off, 32'h010, rd);
        wb(1'b1, freq_setpoint_off, {24'h0, clv_setpoint(1)}, rd);
        wb(1'b1, motor_mode_off, 32'h0A, rd);
        repeat (120) @(posedge ref_clk);
        wb(1'b0, integrator_high_off, 32'h0, rd);
        chk({31'h0, rd !== 32'h00}, 32'h1);
        // large overall gain overflows, opens the switches and freezes the integrator
        wb(1'b1, motor_mode_off, 32'h2A, rd);
        wb(1'b1, integrator_high_off, 32'h40, rd);
        wb(1'b1, loop_gain_b_off, 32'h1FF, rd);
        wb(1'b0, irq_status_b_off, 32'h0, rd);
        chk(rd, 32'h1);
        wb(1'b0, integrator_high_off, 32'h0, rd);
        repeat (120) @(posedge ref_clk);
        wb(1'b0, integrator_high_off, 32'h0, hi);
        chk(hi, rd);
        // level flag drops once the gain is sane again
        wb(1'b1, loop_gain_b_off, 32'h110, rd);
        wb(1'b0, irq_status_b_off, 32'h0, rd);
        chk(rd, 32'h0);
        wb(1'b1, motor_mode_off, 32'h03, rd);
        repeat (4) @(posedge ref_clk);
        chk({30'h0, motor_enable, motor_out}, 32'h0);
        end_sim();
    end
endmodule : motor_speed_servo_tb
